/* File: video_scale_ratio_control.sv */
/*
 Ratio registers and down-scaling decimators for a video capture path.
 Holds the horizontal and vertical ratios behind an APB slave and thins
 the base sample stream accordingly.
 Assumes samples and line/field markers arrive on clock from the decoder.
*/
`timescale 1ns/1ns

// Overview of operation
// - Horizontal keep rate is one sample per 1 + ratio/4096 input samples.
// - Vertical ratio is 13-bit negative code; zero means no vertical reduction.
// - Vertical ratio uses only five low upper bits plus eight lower bits.
// - Three top upper bits belong to other controls and are replaced by every upper byte write.
// - Single-field codes give the same ratio as both-field codes, capped at 4:1.
// - Codes 0000, 1E00, 1A00, 1200 give 1, 2, 4, 8 to one.
// - Horizontal codes 02AA, 1555, 3AAA give matching line lengths.
// - Horizontal ratio is upper and lower byte concatenated into 16 bits.
// - Unscaled NTSC lines carry 910 samples, one per sample clock.
// - Line counts are before vertical scaling, pixel counts after.
// - Vertical down-scaling is capped at 16:1, and 4:1 from fields.
module video_scale_ratio_control
   import scale_pkg::*;
#(
   parameter int LINE_W = 11
) (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              rst_n,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic [31:0]            prdata,
   output logic                   pslverr,
   // Incoming sample stream
   input  wire logic              sample_valid,
   input  wire logic [15:0]       sample_data,
   input  wire logic              line_start,
   input  wire logic              field_start,
   // Scaled stream
   output logic                   pix_valid,
   output logic [15:0]            pix_data,
   output logic                   line_keep,
   // Control levels
   output logic                   interlace_sel,
   output logic [2:0]             other_ctrl
);
   typedef enum logic [1:0] {
      AP_IDLE   = 2'b01,
      AP_ACCESS = 2'b10
   } apb_state_e;

   initial begin
      if (LINE_W < 11) $error("video_scale_ratio_control: LINE_W too small");
   end

   apb_state_e        ap_ff;
   logic [7:0]        vert_upper_ff;
   logic [7:0]        vert_lower_ff;
   logic [7:0]        horz_upper_ff;
   logic [7:0]        horz_lower_ff;
   logic [10:0]       line_len_ff;
   logic [LINE_W-1:0] samp_cnt_ff;
   logic [LINE_W-1:0] last_len_ff;
   logic [15:0]       data_d_ff;
   logic              field_mode;
   logic [15:0]       horz_ratio;
   logic [12:0]       vert_ratio;
   logic [12:0]       vert_eff;
   logic [15:0]       vert_step;
   logic              h_keep;
   logic              v_keep;
   logic              line_stb;
   logic [9:0]        word_idx;
   logic              wr_en;
   logic              rd_en;
   logic              hit;
   logic [31:0]       nxt_rdata;

   assign horz_ratio = {horz_upper_ff, horz_lower_ff};
   assign vert_ratio = {vert_upper_ff[VR_UPPER_BITS-1:0], vert_lower_ff};
   assign field_mode = ~vert_upper_ff[INTERLACE_BIT];

   always_comb begin
      vert_eff = vert_ratio;
      if (vert_ratio != '0) begin
         if (field_mode && vert_ratio < VR_MAX_FIELD) begin
            vert_eff = VR_MAX_FIELD;
         end else if (!field_mode && vert_ratio < VR_MAX_FRAME) begin
            vert_eff = VR_MAX_FRAME;
         end
      end
   end

   // negate code to reduction minus one
   // field mode only raises the clamp code to VR_MAX_FIELD
   // Thirteen-bit negation, so a zero code stays zero and keeps every line
   assign vert_step = {3'b000, 13'(~vert_eff + 13'h0001)};

   assign word_idx = paddr[11:2];
   assign wr_en    = psel && penable && pwrite && (ap_ff == AP_ACCESS);
   assign rd_en    = psel && !penable;
   assign line_stb = line_start;

   // APB phase tracker; answer in the first access cycle
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ap_ff <= AP_IDLE;
      end else begin
         case (ap_ff)
            AP_IDLE: begin
               if (psel && !penable) ap_ff <= AP_ACCESS;
            end
            AP_ACCESS: begin
               ap_ff <= AP_IDLE;
            end
            default: ap_ff <= AP_IDLE;
         endcase
      end
   end

   // Address decode and read mux
   always_comb begin
      hit       = 1'b1;
      nxt_rdata = 32'h0000_0000;
      if (word_idx == {2'b00, IDX_VERT_UPPER}) begin
         nxt_rdata[7:0] = vert_upper_ff;
      end else if (word_idx == {2'b00, IDX_VERT_LOWER}) begin
         nxt_rdata[7:0] = vert_lower_ff;
      end else if (word_idx == {2'b00, IDX_HORZ_UPPER}) begin
         nxt_rdata[7:0] = horz_upper_ff;
      end else if (word_idx == {2'b00, IDX_HORZ_LOWER}) begin
         nxt_rdata[7:0] = horz_lower_ff;
      end else if (word_idx == {2'b00, IDX_STATUS}) begin
         nxt_rdata[LINE_W-1:0] = last_len_ff;
      end else if (word_idx == {2'b00, IDX_LINE_CTRL}) begin
         nxt_rdata[10:0] = line_len_ff;
      end else begin
         hit = 1'b0;
      end
   end

   // Response registers, valid during the access cycle
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= rd_en;
         pslverr <= rd_en && !hit;
         prdata  <= (rd_en && !pwrite) ? nxt_rdata : 32'h0000_0000;
      end
   end

   // Register writes; the whole upper byte is software's to merge
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         vert_upper_ff <= RST_BYTE;
         vert_lower_ff <= RST_BYTE;
         horz_upper_ff <= RST_BYTE;
         horz_lower_ff <= RST_BYTE;
         line_len_ff   <= RST_LINE_LEN;
      end else if (wr_en && hit) begin
         if (word_idx == {2'b00, IDX_VERT_UPPER}) begin
            vert_upper_ff <= pwdata[7:0];
         end else if (word_idx == {2'b00, IDX_VERT_LOWER}) begin
            vert_lower_ff <= pwdata[7:0];
         end else if (word_idx == {2'b00, IDX_HORZ_UPPER}) begin
            horz_upper_ff <= pwdata[7:0];
         end else if (word_idx == {2'b00, IDX_HORZ_LOWER}) begin
            horz_lower_ff <= pwdata[7:0];
         end else if (word_idx == {2'b00, IDX_LINE_CTRL}) begin
            line_len_ff <= pwdata[10:0];
         end
      end
   end

   ratio_accum #(.W(16), .FRAC(HFRAC_BITS)) u_hdec (
      .clock   (clock),
      .rst_n   (rst_n),
      .restart (line_stb),
      .step    (horz_ratio),
      .in_stb  (sample_valid),
      .out_stb (h_keep)
   );

   ratio_accum #(.W(16), .FRAC(VFRAC_BITS)) u_vdec (
      .clock   (clock),
      .rst_n   (rst_n),
      .restart (field_start),
      .step    (vert_step),
      .in_stb  (line_stb),
      .out_stb (v_keep)
   );

   // Align sample data with the registered keep strobe
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         data_d_ff <= 16'h0000;
      end else begin
         data_d_ff <= sample_data;
      end
   end

   // Scaled outputs, gated by the current line decision
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pix_valid     <= 1'b0;
         pix_data      <= 16'h0000;
         line_keep     <= 1'b1;
         interlace_sel <= 1'b0;
         other_ctrl    <= 3'b000;
      end else begin
         pix_valid     <= h_keep && line_keep;
         pix_data      <= data_d_ff;
         interlace_sel <= vert_upper_ff[INTERLACE_BIT];
         other_ctrl    <= vert_upper_ff[7:5] & VR_OTHER_MASK[7:5];
         if (v_keep) begin
            line_keep <= 1'b1;
         end else if (line_stb) begin
            line_keep <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         samp_cnt_ff <= '0;
         last_len_ff <= '0;
      end else if (line_stb) begin
         last_len_ff <= samp_cnt_ff;
         samp_cnt_ff <= '0;
      end else if (h_keep) begin
         samp_cnt_ff <= samp_cnt_ff + 1'b1;
      end
   end
endmodule

/* File: scale_pkg.sv */
/*
 Shared constants for the video scale ratio control block: register map,
 field positions, reset values and ratio codes.
 Assumes a 32-bit APB register bus and one 125 MHz clock.
*/
package scale_pkg;
   // Register word indices; byte address is four times the index
   localparam logic [7:0]  IDX_VERT_UPPER  = 8'h13;
   localparam logic [7:0]  IDX_VERT_LOWER  = 8'h14;
   localparam logic [7:0]  IDX_HORZ_UPPER  = 8'h20;
   localparam logic [7:0]  IDX_HORZ_LOWER  = 8'h21;
   localparam logic [7:0]  IDX_STATUS      = 8'h22;
   localparam logic [7:0]  IDX_LINE_CTRL   = 8'h23;
   // Field positions
   localparam int          VR_UPPER_BITS   = 5;
   localparam int          INTERLACE_BIT   = 5;
   localparam logic [7:0]  VR_OTHER_MASK   = 8'hE0;
   // Reset values
   localparam logic [7:0]  RST_BYTE        = 8'h00;
   localparam logic [10:0] RST_LINE_LEN    = 11'h38E; // 910 samples
   // Fixed-point scaling
   localparam int          HFRAC_BITS      = 12;      // 4096 per unit
   localparam int          VFRAC_BITS      = 9;       // 512 per unit
   localparam logic [12:0] VR_MAX_FRAME    = 13'h0200; // 16:1 from frames
   localparam logic [12:0] VR_MAX_FIELD    = 13'h1A00;
endpackage

/* File: ratio_accum.sv */
/*
 Phase accumulator that decimates a sample stream by 1 + ratio/2^FRAC.
 Assumes input strobes on the same clock; restart aligns the phase.
*/
`timescale 1ns/1ns
module ratio_accum #(
   parameter int W    = 16,
   parameter int FRAC = 12
) (
   // Clock and reset
   input  wire logic          clock,
   input  wire logic          rst_n,
   // Control
   input  wire logic          restart,
   input  wire logic [W-1:0]  step,
   // Stream
   input  wire logic          in_stb,
   output logic               out_stb
);
   localparam logic [W+FRAC:0] UNIT = (W+FRAC+1)'(1) << FRAC;

   logic [W+FRAC:0] acc_ff;
   logic            fire;

   initial begin
      if (FRAC >= W + FRAC || W < 2) $error("ratio_accum: bad widths");
   end

   // A sample is kept whenever the accumulator has run out of credit
   assign fire = in_stb && (acc_ff < UNIT);

   // Credit grows by 1+ratio per kept sample, drops by one per sample
   always_ff @(posedge clock) begin
      if (!rst_n || restart) begin
         acc_ff <= '0;
      end else if (in_stb) begin
         if (fire) begin
            acc_ff <= acc_ff + {1'b0, {FRAC{1'b0}}, step} - UNIT + UNIT;
         end else begin
            acc_ff <= acc_ff - UNIT;
         end
      end
   end

   // Registered keep strobe
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         out_stb <= 1'b0;
      end else begin
         out_stb <= fire;
      end
   end
endmodule

/* File: video_scale_ratio_control_props.sv */
/*
 Port checker for the scale ratio block: APB timing, control mirrors, stream.
 Assumes a bind to the top module and byte addresses four times the index.
*/
`timescale 1ns/1ns
module video_scale_ratio_control_props (
   // Clock and reset
   input wire logic        clock,
   input wire logic        rst_n,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   // Streams and controls
   input wire logic        sample_valid,
   input wire logic [15:0] sample_data,
   input wire logic        pix_valid,
   input wire logic [15:0] pix_data,
   input wire logic        line_keep,
   input wire logic        interlace_sel,
   input wire logic [2:0]  other_ctrl
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Access phase qualifier
   wire logic acc = psel && penable;
   wire logic up  = paddr == 12'h04C;

   a_ready_zero_wait: assert property ((psel && !penable) ##1 acc |-> pready)
      else $error("pready late");
   a_ready_idle: assert property (!acc |-> !pready)
      else $error("pready outside access");
   a_ctrl_mirror: assert property (other_ctrl[0] == interlace_sel)
      else $error("interlace select mismatch");
   a_upper_write: assert property (acc && pwrite && pready && up |-> ##2 other_ctrl == $past(pwdata[7:5], 2))
      else $error("upper bits not taken");
   a_upper_read: assert property (acc && !pwrite && pready && up |-> prdata[31:5] == {24'h0, other_ctrl})
      else $error("upper read wrong");
   a_err_unmapped: assert property (pready && paddr > 12'h08F |-> pslverr)
      else $error("unmapped not refused");
   a_pix_cause: assert property (pix_valid |-> $past(sample_valid, 2))
      else $error("pixel without sample");
   a_pix_data: assert property (pix_valid |-> pix_data == $past(sample_data, 2))
      else $error("pixel data wrong");
   c_refused: cover property (pready && pslverr);
   c_pixel: cover property (pix_valid);
   c_drop: cover property (!line_keep);
endmodule

bind video_scale_ratio_control video_scale_ratio_control_props i_props (.clock, .rst_n, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .sample_valid, .sample_data,
   .pix_valid, .pix_data, .line_keep, .interlace_sel, .other_ctrl);

/* File: video_scale_ratio_control_tb.sv */
/*
 Self-checking bench for the scale ratio block: registers over APB, line counts.
 Assumes zero wait state APB and one line_keep level per line.
*/
`timescale 1ns/1ns
module video_scale_ratio_control_tb;
   logic        clock, rst_n, psel, penable, pwrite, sample_valid, line_start, field_start;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] sample_data, pix_data;
   logic        pready, pslverr, pix_valid, line_keep, interlace_sel, er;
   logic [2:0]  other_ctrl;
   int          errors, compares, cycles, pix_cnt, kept;
   logic [11:0] ra [6] = '{12'h04C, 12'h050, 12'h080, 12'h084, 12'h088, 12'h08C};

   video_scale_ratio_control i_dut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pready, .prdata, .pslverr, .sample_valid, .sample_data, .line_start, .field_start,
      .pix_valid, .pix_data, .line_keep, .interlace_sel, .other_ctrl);

   // Clock
   always #4 clock = ~clock;

   // Kept pixel count and hang guard
   always @(posedge clock) begin
      cycles++;
      if (pix_valid === 1'b1) pix_cnt++;
      if (cycles > 20000) begin
         $display("Error at %0t: timeout", $time);
         errors++;
         finish_test();
      end
   end

   task finish_test;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer, held until pready
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clock);
      penable <= 1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   task pulse_line;
      @(posedge clock) line_start <= 1;
      @(posedge clock) line_start <= 0;
   endtask

   // One full line of samples at a horizontal code
   task hline(input logic [15:0] c, input int n);
      int t;
      t = (c != 0);
      apb(1, 12'h080, {24'h0, c[15:8]});
      apb(1, 12'h084, {24'h0, c[7:0]});
      apb(0, 12'h084, 0);
      check(rd, {24'h0, c[7:0]});
      pulse_line();
      pix_cnt = 0;
      repeat (910) @(posedge clock) begin
         sample_valid <= 1;
         sample_data <= sample_data + 16'h0001;
      end
      @(posedge clock) sample_valid <= 0;
      repeat (3) @(posedge clock);
      check((pix_cnt - n <= t && n - pix_cnt <= t) ? n : pix_cnt, n);
      pulse_line();
      apb(0, 12'h088, 0);
      check((int'(rd) - n <= t && n - int'(rd) <= t) ? n : rd, n);
   endtask

   // Eight lines of a field at a vertical code
   task vtest(input logic [2:0] top, input logic [12:0] c, input int n);
      apb(1, 12'h04C, {24'h0, top, c[12:8]});
      apb(1, 12'h050, {24'h0, c[7:0]});
      check({29'h0, other_ctrl}, {29'h0, top});
      @(posedge clock) field_start <= 1;
      @(posedge clock) field_start <= 0;
      kept = 0;
      repeat (8) begin
         pulse_line();
         repeat (3) @(posedge clock);
         kept += (line_keep === 1'b1);
      end
      check(kept, n);
   endtask

   // Main sequence
   initial begin
      {clock, rst_n, psel, penable, pwrite, sample_valid, line_start, field_start} = 0;
      paddr = 0; pwdata = 0; sample_data = 0;
      repeat (12) @(posedge clock);
      rst_n <= 1;
      @(posedge clock);
      check({31'h0, line_keep}, 1);
      for (int i = 0; i < 6; i++) begin
         apb(0, ra[i], 0);
         check(rd, i == 5 ? 32'h38E : 32'h0);
      end
      apb(0, 12'h0FC, 0);
      check({er, rd[30:0]}, 32'h8000_0000);
      hline(16'h0000, 910);
      hline(16'h02AA, 780);
      hline(16'h1555, 390);
      hline(16'h3AAA, 195);
      apb(1, 12'h04C, 32'hFFFF_FFFF);
      apb(0, 12'h04C, 0);
      check(rd, 32'hFF);
      check({31'h0, interlace_sel}, 1);
      vtest(3'b001, 13'h0000, 8);
      vtest(3'b101, 13'h1E00, 4);
      vtest(3'b011, 13'h1A00, 2);
      vtest(3'b001, 13'h1200, 1);
      vtest(3'b001, 13'h1000, 1);
      vtest(3'b000, 13'h1E00, 4);
      vtest(3'b110, 13'h1A00, 2);
      vtest(3'b110, 13'h1200, 2);
      apb(0, 12'h04C, 0);
      apb(1, 12'h04C, (rd & 32'hE0) | 32'h1E);
      apb(1, 12'h050, 0);
      apb(0, 12'h04C, 0);
      check(rd, 32'hDE);
      finish_test();
   end
endmodule
